// file: prescaled_reload_timer.sv
`timescale 1ns/10ps
`default_nettype none
module prescaled_reload_timer #(
	parameter int PRESCALE_W = 12,
	parameter int COUNT_W = 16
) (
	// clock and reset
	input wire logic REF_CLK_I,
	input wire logic RESETN_I,
	// register port
	input wire logic [5:0] REG_ADDR_I,
	input wire logic [7:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [7:0] REG_RDATA_O,
	// control from neighbouring registers
	input wire logic START_NOW_I,
	input wire logic STOP_NOW_I,
	input wire logic EVEN_DIVIDE_SELECT_I,
	input wire logic INITIAL_FIELD_ON_I,
	// protocol events and gate sources
	input wire logic TX_END_I,
	input wire logic FIELD_ON_I,
	input wire logic SIGNAL_INPUT_PIN_I,
	input wire logic FIRST_AUXILIARY_SIGNAL_I,
	input wire logic THIRD_ANALOG_PIN_I,
	// status
	output logic RUNNING_O,
	output logic TIMER_ZERO_FLAG_O
);

	if (PRESCALE_W != 12 || COUNT_W != 16) begin : g_check
		$error("timer serves only a 12-bit prescaler and 16-bit counter");
	end

	// the accumulator cannot make a carrier at or above the reference
	if (timer_pkg::PHASE_STEP >= timer_pkg::PHASE_MODULUS) begin : g_phase_check
		$error("carrier step must stay below the accumulator modulus");
	end

	timer_pkg::mode_t mode_r;
	timer_pkg::mode_t mode_nxt;
	logic [7:0] prescale_low_bits_r;
	logic [7:0] prescale_low_bits_nxt;
	logic [7:0] reload_high_bits_r;
	logic [7:0] reload_high_bits_nxt;
	logic [7:0] reload_low_bits_r;
	logic [7:0] reload_low_bits_nxt;
	logic [7:0] rdata_nxt;
	logic [PRESCALE_W-1:0] prescale_value;
	logic [COUNT_W-1:0] reload_value;
	logic [COUNT_W-1:0] count_r;
	logic [COUNT_W-1:0] count_nxt;
	timer_pkg::timer_state_t state_r;
	timer_pkg::timer_state_t state_nxt;
	logic zero_nxt;
	logic running_nxt;
	logic field_on_r;
	logic field_on_nxt;
	logic field_rise;
	logic field_start;
	logic auto_start_event;
	logic start_event;
	logic gate_open;
	logic divider_enable;
	logic count_at_last;
	logic tick;

	////////////////////////////////////////////////////////////////////////
	// register file
	always_comb begin
		mode_nxt = mode_r;
		prescale_low_bits_nxt = prescale_low_bits_r;
		reload_high_bits_nxt = reload_high_bits_r;
		reload_low_bits_nxt = reload_low_bits_r;
		if (REG_WR_I) begin
			unique case (REG_ADDR_I)
				timer_pkg::ADDR_MODE: begin
					mode_nxt = timer_pkg::mode_t'(REG_WDATA_I);
				end
				timer_pkg::ADDR_PRESCALE_LOW: begin
					prescale_low_bits_nxt = REG_WDATA_I;
				end
				timer_pkg::ADDR_RELOAD_HIGH: begin
					reload_high_bits_nxt = REG_WDATA_I;
				end
				timer_pkg::ADDR_RELOAD_LOW: begin
					reload_low_bits_nxt = REG_WDATA_I;
				end
				default: begin
				end
			endcase
		end
		// counter bytes have no write path; unmapped reads give zero
		rdata_nxt = REG_RDATA_O;
		if (REG_RD_I) begin
			unique case (REG_ADDR_I)
				timer_pkg::ADDR_MODE: rdata_nxt = mode_r;
				timer_pkg::ADDR_PRESCALE_LOW: rdata_nxt = prescale_low_bits_r;
				timer_pkg::ADDR_RELOAD_HIGH: rdata_nxt = reload_high_bits_r;
				timer_pkg::ADDR_RELOAD_LOW: rdata_nxt = reload_low_bits_r;
				timer_pkg::ADDR_COUNT_HIGH: rdata_nxt = count_r[15:8];
				timer_pkg::ADDR_COUNT_LOW: rdata_nxt = count_r[7:0];
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			mode_r <= timer_pkg::mode_t'(timer_pkg::RESET_MODE);
			prescale_low_bits_r <= timer_pkg::RESET_PRESCALE_LOW;
			reload_high_bits_r <= timer_pkg::RESET_RELOAD_BYTE;
			reload_low_bits_r <= timer_pkg::RESET_RELOAD_BYTE;
			REG_RDATA_O <= timer_pkg::RESET_RDATA;
		end else begin
			mode_r <= mode_nxt;
			prescale_low_bits_r <= prescale_low_bits_nxt;
			reload_high_bits_r <= reload_high_bits_nxt;
			reload_low_bits_r <= reload_low_bits_nxt;
			REG_RDATA_O <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// start sources and gate
	assign prescale_value = {mode_r.prescale_high_bits, prescale_low_bits_r};
	assign reload_value = {reload_high_bits_r, reload_low_bits_r};

	// field on only counts when the initial option asks for it
	always_comb begin
		field_on_nxt = FIELD_ON_I;
		field_rise = FIELD_ON_I && !field_on_r;
		field_start = INITIAL_FIELD_ON_I && field_rise;
		auto_start_event = mode_r.protocol_auto_start &&
			(TX_END_I || field_start);
		start_event = START_NOW_I || auto_start_event;
	end

	always_comb begin
		unique case (mode_r.gate_source_select)
			timer_pkg::GATE_NONE: gate_open = 1'b1;
			timer_pkg::GATE_SIGNAL_INPUT: gate_open = SIGNAL_INPUT_PIN_I;
			timer_pkg::GATE_FIRST_AUX: gate_open = FIRST_AUXILIARY_SIGNAL_I;
			timer_pkg::GATE_THIRD_ANALOG: gate_open = THIRD_ANALOG_PIN_I;
		endcase
	end

	assign divider_enable = state_r == timer_pkg::ST_RUNNING && gate_open;

	// divider freezes with the gate so a closed gate costs no phase
	tick_divider #(
		.PRESCALE_W(PRESCALE_W)
	) u_tick_divider (
		.clk_i(REF_CLK_I),
		.resetn_i(RESETN_I),
		.restart_i(start_event),
		.enable_i(divider_enable),
		.prescale_value_i(prescale_value),
		.even_divide_select_i(EVEN_DIVIDE_SELECT_I),
		.tick_o(tick)
	);

	////////////////////////////////////////////////////////////////////////
	// counter and run state
	// one tick left means the next tick lands on zero
	assign count_at_last = count_r <= COUNT_W'(1);

	always_comb begin
		count_nxt = count_r;
		state_nxt = state_r;
		zero_nxt = 1'b0;
		// start beats stop so a restart never loses its event
		if (start_event) begin
			count_nxt = reload_value;
			state_nxt = timer_pkg::ST_RUNNING;
		end else if (STOP_NOW_I) begin
			state_nxt = timer_pkg::ST_STOPPED;
		end else if (state_r == timer_pkg::ST_RUNNING && tick) begin
			if (count_r == '0 && mode_r.auto_reload_enable) begin
				count_nxt = reload_value;
			end else if (count_at_last && !mode_r.auto_reload_enable) begin
				count_nxt = '0;
				state_nxt = timer_pkg::ST_STOPPED;
				zero_nxt = 1'b1;
			end else begin
				count_nxt = count_r - 1'b1;
			end
		end
		running_nxt = (state_nxt == timer_pkg::ST_RUNNING);
	end

	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			count_r <= timer_pkg::RESET_COUNT;
			state_r <= timer_pkg::ST_STOPPED;
			field_on_r <= 1'b0;
			RUNNING_O <= 1'b0;
			TIMER_ZERO_FLAG_O <= 1'b0;
		end else begin
			count_r <= count_nxt;
			state_r <= state_nxt;
			field_on_r <= field_on_nxt;
			// status leaves straight from flops
			RUNNING_O <= running_nxt;
			TIMER_ZERO_FLAG_O <= zero_nxt;
		end
	end

endmodule : prescaled_reload_timer
`default_nettype wire

// file: test_prescaled_reload_timer.sv
`timescale 1ns/10ps
`default_nettype none
module test_prescaled_reload_timer;
	logic clk, rst_n, wr, rd, sn, sp, ev, ifo, txe, fon, sig, aux, an3;
	logic [5:0] adr;
	logic [7:0] wd, rdo;
	logic run, zf;
	int error_cnt = 0, num_checks = 0, cyc = 0, n, x, g;
	bit [31:0] sd = 32'h74D7;
	// register and counter model, kept from the map alone
	int shadow [64];
	int count_m = 0;
	prescaled_reload_timer prescaled_reload_timer_inst (.REF_CLK_I(clk),
		.RESETN_I(rst_n), .REG_ADDR_I(adr), .REG_WDATA_I(wd), .REG_WR_I(wr),
		.REG_RD_I(rd), .REG_RDATA_O(rdo), .START_NOW_I(sn), .STOP_NOW_I(sp),
		.EVEN_DIVIDE_SELECT_I(ev), .INITIAL_FIELD_ON_I(ifo), .TX_END_I(txe),
		.FIELD_ON_I(fon), .SIGNAL_INPUT_PIN_I(sig),
		.FIRST_AUXILIARY_SIGNAL_I(aux), .THIRD_ANALOG_PIN_I(an3),
		.RUNNING_O(run), .TIMER_ZERO_FLAG_O(zf));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ceiling well above the slowest case, about 10k cycles in all
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	function automatic bit [31:0] xs();
		sd ^= sd << 13;
		sd ^= sd >> 17;
		sd ^= sd << 5;
		return sd;
	endfunction : xs
	// counter bytes only valid while no tick has landed since the start
	function automatic logic [7:0] model_rd(int a);
		if (a == 6'h2E)
			return 8'(count_m >> 8);
		if (a == 6'h2F)
			return 8'(count_m);
		return 8'(shadow[a % 64]);
	endfunction : model_rd
	task tk();
		@(posedge clk);
		#1;
	endtask : tk
	task check(string nm, logic [15:0] s, logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s exp %h seen %h", nm, e, s);
		end
	endtask : check
	task wreg(logic [5:0] a, logic [7:0] d);
		tk();
		adr = a;
		wd = d;
		wr = 1'h1;
		if (a >= 6'h2A && a <= 6'h2D)
			shadow[a] = d;
		tk();
		wr = 1'h0;
	endtask : wreg
	task rchk(logic [5:0] a, logic [7:0] e);
		tk();
		adr = a;
		rd = 1'h1;
		tk();
		rd = 1'h0;
		check("rdata", {8'h00, rdo}, {8'h00, e});
	endtask : rchk
	// write, then read on the very next edge
	task wrchk(logic [5:0] a, logic [7:0] d);
		tk();
		adr = a;
		wd = d;
		wr = 1'h1;
		if (a >= 6'h2A && a <= 6'h2D)
			shadow[a] = d;
		tk();
		wr = 1'h0;
		rd = 1'h1;
		tk();
		rd = 1'h0;
		check("rdata", {8'h00, rdo}, {8'h00, model_rd(a)});
	endtask : wrchk
	task go(logic [15:0] r);
		wreg(6'h2C, r[15:8]);
		wreg(6'h2D, r[7:0]);
		tk();
		sn = 1'h1;
		tk();
		sn = 1'h0;
		count_m = int'(r);
	endtask : go
	task halt();
		tk();
		sp = 1'h1;
		tk();
		sp = 1'h0;
	endtask : halt
	// cycles to the zero flag against reload times divider enables
	task run_case(logic [7:0] m, logic [7:0] pl, logic e, logic [15:0] r);
		wreg(6'h2A, m);
		wreg(6'h2B, pl);
		ev = e;
		go(r);
		n = 0;
		while (zf !== 1'h1 && n < 9000) begin
			tk();
			n++;
		end
		x = int'(r) * (2 * int'({m[3:0], pl}) + 1 + int'(e)) * 20000 / 1356;
		check("ticks", 16'(n > x - 20 && n < x + 20), 16'h0001);
	endtask : run_case
	task tally_and_finish();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		{rst_n, wr, rd, sn, sp, ev, ifo, txe, fon, sig, aux, an3} = '0;
		{adr, wd} = '0;
		repeat (16) @(posedge clk);
		#1;
		rst_n = 1'h1;
		for (g = 6'h2A; g <= 6'h30; g++)
			rchk(6'(g), model_rd(g));
		// first half reads after an idle edge, second half back to back
		for (g = 0; g < 12; g++) begin
			x = xs();
			if (g < 6) begin
				wreg(6'(6'h2A + g), x[7:0]);
				rchk(6'(6'h2A + g), model_rd(6'h2A + g));
			end else begin
				wrchk(6'(6'h24 + g), x[7:0]);
			end
		end
		$display("test registers done");
		run_case(8'h00, 8'h03, 1'h0, 16'h0004);
		run_case(8'h00, 8'h03, 1'h1, 16'h0004);
		run_case(8'h01, 8'h00, 1'h0, 16'h0001);
		$display("test divider done");
		go(16'h0005);
		wreg(6'h2D, 8'hAA);
		rchk(6'h2F, model_rd(6'h2F));
		halt();
		repeat (50) tk();
		rchk(6'h2F, model_rd(6'h2F));
		go(16'h00AA);
		rchk(6'h2F, model_rd(6'h2F));
		halt();
		$display("test reload done");
		wreg(6'h2B, 8'h00);
		wreg(6'h2A, 8'h10);
		go(16'h0001);
		n = 0;
		repeat (300) begin
			tk();
			n += int'(zf);
		end
		check("flags", 16'(n), 16'h0000);
		check("run", {15'h0, run}, 16'h0001);
		halt();
		check("run", {15'h0, run}, 16'h0000);
		$display("test auto reload done");
		for (g = 1; g < 4; g++) begin
			wreg(6'h2A, 8'(g << 5));
			go(16'h0003);
			repeat (100) tk();
			rchk(6'h2F, model_rd(6'h2F));
			{sig, aux, an3} = 3'(4 >> (g - 1));
			repeat (100) tk();
			check("run", {15'h0, run}, 16'h0000);
			{sig, aux, an3} = 3'h0;
		end
		$display("test gating done");
		wreg(6'h2A, 8'h80);
		tk();
		txe = 1'h1;
		tk();
		txe = 1'h0;
		check("run", {15'h0, run}, 16'h0001);
		halt();
		ifo = 1'h1;
		fon = 1'h1;
		repeat (3) tk();
		check("run", {15'h0, run}, 16'h0001);
		halt();
		$display("test auto start done");
		tally_and_finish();
	end
endmodule : test_prescaled_reload_timer
`default_nettype wire

// file: tick_divider.sv
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
	parameter int PRESCALE_W = 12
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// control
	input wire logic restart_i,
	input wire logic enable_i,
	input wire logic [PRESCALE_W-1:0] prescale_value_i,
	input wire logic even_divide_select_i,
	// output
	output logic tick_o
);

	logic [15:0] phase_r;
	logic [15:0] phase_nxt;
	logic carrier_en;
	logic [PRESCALE_W:0] div_r;
	logic [PRESCALE_W:0] div_nxt;
	logic [PRESCALE_W:0] last;
	logic tick_nxt;

	////////////////////////////////////////////////////////////////////////
	// fractional accumulator: 13.56 MHz enable, jitter of one ref cycle
	always_comb begin
		carrier_en = 1'b0;
		phase_nxt = phase_r + timer_pkg::PHASE_STEP;
		if (phase_nxt >= timer_pkg::PHASE_MODULUS) begin
			phase_nxt = phase_nxt - timer_pkg::PHASE_MODULUS;
			carrier_en = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// divide by 2p+1 or 2p+2 carrier periods
	always_comb begin
		last = {prescale_value_i, even_divide_select_i};
		div_nxt = div_r;
		tick_nxt = 1'b0;
		if (restart_i) begin
			div_nxt = '0;
		end else if (enable_i && carrier_en) begin
			if (div_r >= last) begin
				div_nxt = '0;
				tick_nxt = 1'b1;
			end else begin
				div_nxt = div_r + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			phase_r <= 16'h0000;
			div_r <= '0;
			tick_o <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			div_r <= div_nxt;
			tick_o <= tick_nxt;
		end
	end

endmodule : tick_divider
`default_nettype wire

// file: timer_pkg.sv
`default_nettype none
package timer_pkg;

	// register indices on the 6-bit register address
	localparam logic [5:0] ADDR_MODE = 6'h2A;
	localparam logic [5:0] ADDR_PRESCALE_LOW = 6'h2B;
	localparam logic [5:0] ADDR_RELOAD_HIGH = 6'h2C;
	localparam logic [5:0] ADDR_RELOAD_LOW = 6'h2D;
	localparam logic [5:0] ADDR_COUNT_HIGH = 6'h2E;
	localparam logic [5:0] ADDR_COUNT_LOW = 6'h2F;

	// values after reset
	localparam logic [7:0] RESET_MODE = 8'h00;
	localparam logic [7:0] RESET_PRESCALE_LOW = 8'h00;
	localparam logic [7:0] RESET_RELOAD_BYTE = 8'h00;
	localparam logic [15:0] RESET_COUNT = 16'h0000;
	localparam logic [7:0] RESET_RDATA = 8'h00;

	// gate selections
	localparam logic [1:0] GATE_NONE = 2'h0;
	localparam logic [1:0] GATE_SIGNAL_INPUT = 2'h1;
	localparam logic [1:0] GATE_FIRST_AUX = 2'h2;
	localparam logic [1:0] GATE_THIRD_ANALOG = 2'h3;

	// carrier of 13.56 MHz from the 200 MHz clock, in units of 10 kHz
	localparam int REF_CLK_KHZ = 200000;
	localparam int CARRIER_KHZ = 13560;
	localparam logic [15:0] PHASE_STEP = 16'(CARRIER_KHZ / 10);
	localparam logic [15:0] PHASE_MODULUS = 16'(REF_CLK_KHZ / 10);

	// mode register layout, bit 7 down to bit 0
	typedef struct packed {
		logic protocol_auto_start;
		logic [1:0] gate_source_select;
		logic auto_reload_enable;
		logic [3:0] prescale_high_bits;
	} mode_t;

	typedef enum logic {
		ST_STOPPED = 1'b0,
		ST_RUNNING = 1'b1
	} timer_state_t;

endpackage : timer_pkg
`default_nettype wire

// file: timer_properties.sv
`timescale 1ns/10ps
`default_nettype none
module timer_properties (
	// clock, reset, register port
	input wire logic REF_CLK_I,
	input wire logic RESETN_I,
	input wire logic [5:0] REG_ADDR_I,
	input wire logic [7:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [7:0] REG_RDATA_O,
	// events and status
	input wire logic START_NOW_I,
	input wire logic STOP_NOW_I,
	input wire logic TX_END_I,
	input wire logic RUNNING_O,
	input wire logic TIMER_ZERO_FLAG_O
);
	// mode shadow, auto bits are not on the ports
	logic [7:0] mode_r;
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RESETN_I);
	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I)
			mode_r <= 8'h00;
		else if (REG_WR_I && REG_ADDR_I == 6'h2A)
			mode_r <= REG_WDATA_I;
	end
	a_reg_read_back: assert property (
		REG_WR_I && REG_ADDR_I inside {[6'h2A:6'h2D]}
		##1 REG_RD_I && !REG_WR_I && $stable(REG_ADDR_I)
		|=> REG_RDATA_O == $past(REG_WDATA_I, 2)) else $error("read back");
	a_start_runs: assert property (
		START_NOW_I |=> RUNNING_O) else $error("no start");
	a_stop_halts: assert property (
		STOP_NOW_I && !START_NOW_I && !mode_r[7] |=> !RUNNING_O)
		else $error("no stop");
	a_idle_stays: assert property (
		!RUNNING_O && !START_NOW_I && !mode_r[7] |=> !RUNNING_O)
		else $error("stray start");
	a_tx_end_starts: assert property (
		mode_r[7] && TX_END_I |=> RUNNING_O) else $error("no auto start");
	a_flag_stops: assert property (
		TIMER_ZERO_FLAG_O |-> !RUNNING_O) else $error("flag while running");
	a_flag_pulse: assert property (
		TIMER_ZERO_FLAG_O |=> !TIMER_ZERO_FLAG_O) else $error("long flag");
	a_flag_cause: assert property (
		TIMER_ZERO_FLAG_O |-> $past(RUNNING_O) && !$past(mode_r[4]))
		else $error("flag cause");
	c_start: cover property (START_NOW_I);
	c_read_back: cover property (REG_WR_I ##1 REG_RD_I && !REG_WR_I);
	c_zero: cover property (TIMER_ZERO_FLAG_O);
	c_tx_end: cover property (mode_r[7] && TX_END_I);
endmodule : timer_properties
bind prescaled_reload_timer timer_properties timer_properties_inst (
	.REF_CLK_I, .RESETN_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I,
	.REG_RDATA_O, .START_NOW_I, .STOP_NOW_I, .TX_END_I, .RUNNING_O,
	.TIMER_ZERO_FLAG_O);
`default_nettype wire
